/* File: verilog/pcgsr_params.svh */
// Register map, field positions and reset values of the peripheral clock gate,
// kernel clock select and soft reset block.
// Assumes byte addresses on a 32-bit AXI4-Lite register bus.
`ifndef PCGSR_PARAMS_SVH
`define PCGSR_PARAMS_SVH

`define PCGSR_ADDR_GATE2     32'h4000_1824
`define PCGSR_ADDR_KSEL      32'h4000_1840
`define PCGSR_ADDR_SRST1     32'h4000_1860

`define PCGSR_GATE2_MASK     32'h182E_9C45
`define PCGSR_KSEL_MASK      32'h0300_0F01
`define PCGSR_SRST1_MASK     32'hC3C0_401D

`define PCGSR_GATE2_RST      32'h0000_0000
`define PCGSR_KSEL_RST       32'h0000_0000
`define PCGSR_SRST1_RST      32'h0000_0000
`define PCGSR_CAL_GATE_RST   1'b0
`define PCGSR_CAL_SEL_RST    2'b00

`define PCGSR_GATE_FLASH     19
`define PCGSR_GATE_WDT       17
`define PCGSR_GATE_CAL       11
`define PCGSR_SEL_T50_LSB    24
`define PCGSR_SEL_LPU_LSB    10
`define PCGSR_SEL_CAL_LSB    8
`define PCGSR_SEL_WDT        0
`define PCGSR_LPU_RESERVED   2'b11

`define PCGSR_RESP_OKAY      2'b00
`define PCGSR_RESP_SLVERR    2'b10

`endif

/* File: verilog/pcgsr_pkg.sv */
// Types of the peripheral clock gate, kernel clock select and soft reset block.
// Assumes the constants of pcgsr_params.svh.
package pcgsr_pkg;

   typedef struct packed {
      logic        aw_rdy;
      logic        w_rdy;
      logic [31:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        ar_rdy;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [31:0] gate;
      logic [31:0] ksel;
      logic [31:0] srst;
      logic        wdt_osc;
   } pcgsr_state_s;

   typedef struct packed {
      logic        cal_gate;
      logic [1:0]  cal_sel;
   } pcgsr_keep_s;

endpackage

/* File: verilog/pcgsr_top.sv */
// Peripheral clock gates, kernel clock source selectors and soft resets.
// Assumes an AXI4-Lite master on clk_sys and clock gating cells and muxes outside.
`timescale 1ns/10ps
`include "pcgsr_params.svh"

module pcgsr_top
(
   // Clock and resets.
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        por_nrst,
   // AXI4-Lite write address and data.
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Device status and options.
   input  wire logic        flash_busy,
   input  wire logic        watchdog_config_option,
   // Clock gates and kernel clock selectors.
   output logic [31:0]      clk_gate_en,
   output logic             watchdog_rc_osc_en,
   output logic [1:0]       timer50_source_sel,
   output logic [1:0]       lowpower_uart_source_sel,
   output logic [1:0]       calendar_source_sel,
   output logic             watchdog_source_sel,
   // Peripheral soft resets, active high levels.
   output logic [31:0]      soft_reset
);

   pcgsr_pkg::pcgsr_state_s st_r;
   pcgsr_pkg::pcgsr_state_s st_nxt;
   pcgsr_pkg::pcgsr_keep_s  kp_r;
   pcgsr_pkg::pcgsr_keep_s  kp_nxt;
   logic                    do_wr;
   logic [31:0]             gate_view;
   logic [31:0]             ksel_view;
   logic [31:0]             wr_gate;
   logic [31:0]             wr_ksel;
   logic [31:0]             wr_srst;

   // Merges a write into a word byte by byte under the strobes.
   function automatic logic [31:0] merge_bytes
   (
      input logic [31:0] old_val,
      input logic [31:0] new_val,
      input logic [3:0]  strb
   );
      logic [31:0] res;
      res = old_val;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = new_val[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // A write is done once both address and data are held and no response waits.
   assign do_wr = !st_r.aw_rdy && !st_r.w_rdy && !st_r.bvalid;

   // Register views with the bits that only power-on or wake reset clears.
   always_comb
   begin
      gate_view = st_r.gate;
      gate_view[`PCGSR_GATE_CAL] = kp_r.cal_gate;
      ksel_view = st_r.ksel;
      ksel_view[`PCGSR_SEL_CAL_LSB +: 2] = kp_r.cal_sel;
   end

   always_comb
   begin
      st_nxt = st_r;
      kp_nxt = kp_r;
      wr_gate = merge_bytes(gate_view, st_r.w_data, st_r.w_strb) & `PCGSR_GATE2_MASK;
      wr_ksel = merge_bytes(ksel_view, st_r.w_data, st_r.w_strb) & `PCGSR_KSEL_MASK;
      wr_srst = merge_bytes(st_r.srst, st_r.w_data, st_r.w_strb) & `PCGSR_SRST1_MASK;

      if (flash_busy)
      begin
         wr_gate[`PCGSR_GATE_FLASH] = st_r.gate[`PCGSR_GATE_FLASH];
      end
      if (wr_ksel[`PCGSR_SEL_LPU_LSB +: 2] == `PCGSR_LPU_RESERVED)
      begin
         wr_ksel[`PCGSR_SEL_LPU_LSB +: 2] = st_r.ksel[`PCGSR_SEL_LPU_LSB +: 2];
      end

      if (s_axi_awvalid && st_r.aw_rdy)
      begin
         st_nxt.aw_rdy = 1'b0;
         st_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.w_rdy)
      begin
         st_nxt.w_rdy = 1'b0;
         st_nxt.w_data = s_axi_wdata;
         st_nxt.w_strb = s_axi_wstrb;
      end

      if (do_wr)
      begin
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = `PCGSR_RESP_OKAY;
         case (st_r.aw_addr)
            `PCGSR_ADDR_GATE2:
            begin
               st_nxt.gate = wr_gate;
               st_nxt.gate[`PCGSR_GATE_CAL] = 1'b0;
               kp_nxt.cal_gate = wr_gate[`PCGSR_GATE_CAL];
            end
            `PCGSR_ADDR_KSEL:
            begin
               st_nxt.ksel = wr_ksel;
               st_nxt.ksel[`PCGSR_SEL_CAL_LSB +: 2] = 2'b00;
               kp_nxt.cal_sel = wr_ksel[`PCGSR_SEL_CAL_LSB +: 2];
            end
            `PCGSR_ADDR_SRST1:
            begin
               st_nxt.srst = wr_srst;
            end
            default:
            begin
               st_nxt.bresp = `PCGSR_RESP_SLVERR;
            end
         endcase
      end
      if (st_r.bvalid && s_axi_bready)
      begin
         st_nxt.bvalid = 1'b0;
         st_nxt.aw_rdy = 1'b1;
         st_nxt.w_rdy = 1'b1;
      end

      if (s_axi_arvalid && st_r.ar_rdy)
      begin
         st_nxt.ar_rdy = 1'b0;
         st_nxt.rvalid = 1'b1;
         st_nxt.rresp = `PCGSR_RESP_OKAY;
         case (s_axi_araddr)
            `PCGSR_ADDR_GATE2:
            begin
               st_nxt.rdata = gate_view;
            end
            `PCGSR_ADDR_KSEL:
            begin
               st_nxt.rdata = ksel_view;
            end
            `PCGSR_ADDR_SRST1:
            begin
               st_nxt.rdata = st_r.srst;
            end
            default:
            begin
               st_nxt.rdata = 32'h0000_0000;
               st_nxt.rresp = `PCGSR_RESP_SLVERR;
            end
         endcase
      end
      if (st_r.rvalid && s_axi_rready)
      begin
         st_nxt.rvalid = 1'b0;
         st_nxt.ar_rdy = 1'b1;
      end

      // The option keeps the oscillator running whatever the gate bit says.
      st_nxt.wdt_osc = st_nxt.gate[`PCGSR_GATE_WDT] | watchdog_config_option;
   end

   always_ff @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r.aw_rdy <= 1'b1;
         st_r.w_rdy <= 1'b1;
         st_r.aw_addr <= 32'h0000_0000;
         st_r.w_data <= 32'h0000_0000;
         st_r.w_strb <= 4'h0;
         st_r.bvalid <= 1'b0;
         st_r.bresp <= `PCGSR_RESP_OKAY;
         st_r.ar_rdy <= 1'b1;
         st_r.rvalid <= 1'b0;
         st_r.rdata <= 32'h0000_0000;
         st_r.rresp <= `PCGSR_RESP_OKAY;
         st_r.gate <= `PCGSR_GATE2_RST;
         st_r.ksel <= `PCGSR_KSEL_RST;
         st_r.srst <= `PCGSR_SRST1_RST;
         st_r.wdt_osc <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // These bits survive every reset but power-on and deep-sleep-3 wake.
   always_ff @(posedge clk_sys or negedge por_nrst)
   begin
      if (!por_nrst)
      begin
         kp_r.cal_gate <= `PCGSR_CAL_GATE_RST;
         kp_r.cal_sel <= `PCGSR_CAL_SEL_RST;
      end
      else
      begin
         kp_r <= kp_nxt;
      end
   end

   assign s_axi_awready = st_r.aw_rdy;
   assign s_axi_wready = st_r.w_rdy;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_arready = st_r.ar_rdy;
   assign s_axi_rvalid = st_r.rvalid;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign clk_gate_en = gate_view;
   assign watchdog_rc_osc_en = st_r.wdt_osc;
   assign timer50_source_sel = st_r.ksel[`PCGSR_SEL_T50_LSB +: 2];
   assign lowpower_uart_source_sel = st_r.ksel[`PCGSR_SEL_LPU_LSB +: 2];
   assign calendar_source_sel = kp_r.cal_sel;
   assign watchdog_source_sel = st_r.ksel[`PCGSR_SEL_WDT];
   assign soft_reset = st_r.srst;

   AST_GATE_WRITE: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      do_wr && st_r.aw_addr == `PCGSR_ADDR_GATE2 && st_r.w_strb == 4'hF && !flash_busy
      |=> clk_gate_en == ($past(st_r.w_data) & `PCGSR_GATE2_MASK))
      else $error("Gate register did not take a full write.");

   AST_GATE_RESERVED: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (clk_gate_en & ~`PCGSR_GATE2_MASK) == 32'h0000_0000)
      else $error("A reserved gate bit is set.");

   AST_FLASH_HOLD: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      do_wr && st_r.aw_addr == `PCGSR_ADDR_GATE2 && flash_busy
      |=> $stable(clk_gate_en[`PCGSR_GATE_FLASH]))
      else $error("Flash gate changed during a flash operation.");

   AST_WDT_OSC: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      watchdog_config_option ##1 watchdog_config_option |-> watchdog_rc_osc_en)
      else $error("Watchdog oscillator stopped although the option enables it.");

   AST_CAL_KEEP: assert property (
      @(posedge clk_sys) disable iff (!por_nrst)
      !nrst |=> $stable(clk_gate_en[`PCGSR_GATE_CAL]) && $stable(calendar_source_sel))
      else $error("Calendar bits changed during a system reset.");

   AST_LPU_CODE: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      lowpower_uart_source_sel != `PCGSR_LPU_RESERVED)
      else $error("Low-power UART selector holds the reserved code.");

   AST_SRST_HOLD: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      !(do_wr && st_r.aw_addr == `PCGSR_ADDR_SRST1) |=> soft_reset == $past(soft_reset))
      else $error("Soft reset changed without a software write.");

   AST_SRST_RESERVED: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (soft_reset & ~`PCGSR_SRST1_MASK) == 32'h0000_0000)
      else $error("A reserved soft reset bit is set.");

   AST_BYTE_WRITE: assert property (
      @(posedge clk_sys) disable iff (!nrst || !por_nrst)
      do_wr && st_r.aw_addr == `PCGSR_ADDR_KSEL && !st_r.w_strb[1]
      |=> $stable(lowpower_uart_source_sel) && $stable(calendar_source_sel))
      else $error("A write without its byte strobe changed that byte.");

   AST_WR_RESP: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      do_wr |=> s_axi_bvalid)
      else $error("No write response after a write.");

   AST_KSEL_RESERVED: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      (st_r.ksel & ~`PCGSR_KSEL_MASK) == 32'h0000_0000)
      else $error("A reserved selector bit is set.");

   AST_SRST_SET: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      do_wr && st_r.aw_addr == `PCGSR_ADDR_SRST1 && st_r.w_strb == 4'hF
      |=> soft_reset == ($past(st_r.w_data) & `PCGSR_SRST1_MASK))
      else $error("Soft reset register did not take a full write.");

   AST_WDT_GATE_OSC: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      clk_gate_en[`PCGSR_GATE_WDT] |-> watchdog_rc_osc_en)
      else $error("Watchdog gate is on but its oscillator is stopped.");

   AST_CAL_SEL_WRITE: assert property (
      @(posedge clk_sys) disable iff (!nrst || !por_nrst)
      do_wr && st_r.aw_addr == `PCGSR_ADDR_KSEL && st_r.w_strb[1]
      |=> calendar_source_sel == $past(st_r.w_data[`PCGSR_SEL_CAL_LSB +: 2]))
      else $error("Calendar selector did not take its write.");

   AST_WDT_SEL_WRITE: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      do_wr && st_r.aw_addr == `PCGSR_ADDR_KSEL && st_r.w_strb[0]
      |=> watchdog_source_sel == $past(st_r.w_data[`PCGSR_SEL_WDT]))
      else $error("Watchdog selector did not take its write.");

   AST_T50_SEL_WRITE: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      do_wr && st_r.aw_addr == `PCGSR_ADDR_KSEL && st_r.w_strb[3]
      |=> timer50_source_sel == $past(st_r.w_data[`PCGSR_SEL_T50_LSB +: 2]))
      else $error("Timer50 selector did not take its write.");

   AST_RD_RESP: assert property (
      @(posedge clk_sys) disable iff (!nrst)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("No read response after a read address.");

endmodule

/* File: verification/pcgsr_top_tb.sv */
// Self-checking bench for the clock gate, kernel clock select and soft reset block.
// Assumes pcgsr_top with its register map in pcgsr_params.svh, driven over AXI4-Lite.
`timescale 1ns/10ps
`include "pcgsr_params.svh"

module pcgsr_top_tb;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        por_nrst = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0000_0000;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [31:0] s_axi_araddr = 32'h0000_0000;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   logic        flash_busy = 1'b0;
   logic        watchdog_config_option = 1'b0;
   logic [31:0] clk_gate_en;
   logic        watchdog_rc_osc_en;
   logic [1:0]  timer50_source_sel;
   logic [1:0]  lowpower_uart_source_sel;
   logic [1:0]  calendar_source_sel;
   logic        watchdog_source_sel;
   logic [31:0] soft_reset;
   int          n_mismatch = 0;
   int          num_checks = 0;
   logic [1:0]  lpu_exp;

   pcgsr_top dut
   (
      .clk_sys, .nrst, .por_nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .flash_busy,
      .watchdog_config_option, .clk_gate_en, .watchdog_rc_osc_en, .timer50_source_sel,
      .lowpower_uart_source_sel, .calendar_source_sel, .watchdog_source_sel, .soft_reset
   );

   always #10 clk_sys = ~clk_sys;

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic give_verdict();
      if (n_mismatch == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
      logic ta;
      logic tw;
      logic ha;
      logic hw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ta && tw))
      begin
         @(negedge clk_sys);
         ha = s_axi_awvalid && s_axi_awready;
         hw = s_axi_wvalid && s_axi_wready;
         @(posedge clk_sys);
         if (ha) s_axi_awvalid <= 1'b0;
         if (hw) s_axi_wvalid <= 1'b0;
         ta = ta | ha;
         tw = tw | hw;
      end
      do @(negedge clk_sys); while (s_axi_bvalid !== 1'b1);
      chk("bresp", 32'(er), 32'(s_axi_bresp));
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a, e, input logic [1:0] er);
      logic h;
      h = 1'b0;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!h)
      begin
         @(negedge clk_sys);
         h = s_axi_arvalid && s_axi_arready;
         @(posedge clk_sys);
         if (h) s_axi_arvalid <= 1'b0;
      end
      do @(negedge clk_sys); while (s_axi_rvalid !== 1'b1);
      chk("rdata", e, s_axi_rdata);
      chk("rresp", 32'(er), 32'(s_axi_rresp));
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
   endtask

   initial
   begin
      #100000;
      n_mismatch++;
      give_verdict();
   end

   initial
   begin
      repeat (6) @(posedge clk_sys);
      nrst <= 1'b1;
      por_nrst <= 1'b1;
      rd(`PCGSR_ADDR_GATE2, 32'h0000_0000, `PCGSR_RESP_OKAY);
      rd(`PCGSR_ADDR_KSEL, `PCGSR_KSEL_RST, `PCGSR_RESP_OKAY);
      rd(`PCGSR_ADDR_SRST1, `PCGSR_SRST1_RST, `PCGSR_RESP_OKAY);
      rd(32'h4000_1828, 32'h0000_0000, `PCGSR_RESP_SLVERR);
      wr(`PCGSR_ADDR_GATE2, 32'hFFFF_FFFF, 4'hF, `PCGSR_RESP_OKAY);
      rd(`PCGSR_ADDR_GATE2, 32'h182E_9C45, `PCGSR_RESP_OKAY);
      chk("gate", 32'h182E_9C45, clk_gate_en);
      flash_busy <= 1'b1;
      wr(`PCGSR_ADDR_GATE2, 32'h0000_0000, 4'hF, `PCGSR_RESP_OKAY);
      flash_busy <= 1'b0;
      chk("gate", 32'h0008_0000, clk_gate_en);
      wr(`PCGSR_ADDR_GATE2, 32'h0000_0000, 4'hF, `PCGSR_RESP_OKAY);
      chk("gate", 32'h0000_0000, clk_gate_en);
      chk("osc", 32'h0000_0000, 32'(watchdog_rc_osc_en));
      watchdog_config_option <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("osc", 32'h0000_0001, 32'(watchdog_rc_osc_en));
      watchdog_config_option <= 1'b0;
      lpu_exp = 2'b00;
      for (int i = 0; i < 4; i++)
      begin
         if (i != 3) lpu_exp = 2'(i);
         wr(`PCGSR_ADDR_KSEL, (i << 24) | (i << 10) | (i << 8) | (i & 1), 4'hF,
            `PCGSR_RESP_OKAY);
         chk("t50", 32'(i), 32'(timer50_source_sel));
         chk("lpu", 32'(lpu_exp), 32'(lowpower_uart_source_sel));
         chk("cal", 32'(i), 32'(calendar_source_sel));
         chk("wdt", 32'(i & 1), 32'(watchdog_source_sel));
      end
      wr(`PCGSR_ADDR_KSEL, 32'h0000_0000, 4'b1001, `PCGSR_RESP_OKAY);
      rd(`PCGSR_ADDR_KSEL, 32'h0000_0B00, `PCGSR_RESP_OKAY);
      wr(`PCGSR_ADDR_GATE2, 32'h0000_0800, 4'b0010, `PCGSR_RESP_OKAY);
      wr(`PCGSR_ADDR_SRST1, 32'hFFFF_FFFF, 4'hF, `PCGSR_RESP_OKAY);
      rd(`PCGSR_ADDR_SRST1, 32'hC3C0_401D, `PCGSR_RESP_OKAY);
      repeat (20) @(posedge clk_sys);
      chk("srst", 32'hC3C0_401D, soft_reset);
      wr(`PCGSR_ADDR_SRST1, 32'h0000_0000, 4'b0001, `PCGSR_RESP_OKAY);
      chk("srst", 32'hC3C0_4000, soft_reset);
      wr(`PCGSR_ADDR_SRST1, 32'h0000_0000, 4'hF, `PCGSR_RESP_OKAY);
      chk("srst", 32'h0000_0000, soft_reset);
      wr(32'h4000_1844, 32'hFFFF_FFFF, 4'hF, `PCGSR_RESP_SLVERR);
      rd(`PCGSR_ADDR_KSEL, 32'h0000_0B00, `PCGSR_RESP_OKAY);
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(`PCGSR_ADDR_GATE2, 32'h0000_0800, `PCGSR_RESP_OKAY);
      rd(`PCGSR_ADDR_KSEL, 32'h0000_0300, `PCGSR_RESP_OKAY);
      chk("cal", 32'h0000_0003, 32'(calendar_source_sel));
      @(posedge clk_sys);
      por_nrst <= 1'b0;
      repeat (3) @(posedge clk_sys);
      por_nrst <= 1'b1;
      rd(`PCGSR_ADDR_GATE2, 32'h0000_0000, `PCGSR_RESP_OKAY);
      rd(`PCGSR_ADDR_KSEL, 32'h0000_0000, `PCGSR_RESP_OKAY);
      give_verdict();
   end
endmodule
